/* hw/coc_top.sv */
/*
 * Output conditioner: method routing, neutral zone, cooling gain, ON/OFF,
 * valve drive, clamp and rate limit, with an AHB-Lite register slave.
 * Assumes synchronous inputs, a single clock and zero-wait bus transfers.
 */
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module coc_top #(
    parameter int TICK_CYCLES = coc_pkg::TICK_CYC
) (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Valve position feedback, 0..1000
    input wire logic [15:0] valve_pos,
    // Actuator outputs
    output logic [15:0] heat_mv,
    output logic [15:0] cool_mv,
    output logic heat_on,
    output logic cool_on,
    output logic valve_open,
    output logic valve_close,
    output logic action_direction,
    // Feature enables to neighbouring blocks
    output logic loop_break_alarm_en,
    output logic heater_open_alarm_en,
    output logic at40_en,
    output logic pd_en
);
    import coc_pkg::*;

    typedef struct packed {
        logic [10:0] ctrl;
        logic signed [15:0] mv_in;
        logic signed [15:0] up_lim;
        logic signed [15:0] lo_lim;
        logic [15:0] rate;
        logic signed [15:0] stop_mv;
        logic signed [15:0] err_mv;
        logic signed [15:0] neutral_zone_width;
        logic [15:0] cool_gain;
        logic [15:0] heat_hyst;
        logic [15:0] cool_switch_hyst;
        logic [15:0] travel;
        logic [15:0] valve_db;
        logic [15:0] oc_hyst;
        logic [1:0] stop_act;
        logic [1:0] err_act;
        logic signed [15:0] dev;
        logic signed [15:0] out_mv;
        logic [15:0] heat_mv;
        logic [15:0] cool_mv;
        logic heat_on;
        logic cool_on;
        logic v_open;
        logic v_close;
        logic dir;
        logic [3:0] feat;
        logic [24:0] tick_cnt;
        logic tick;
        coc_cal_e cal;
        logic [15:0] cal_secs;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
    } coc_state_s;

    coc_state_s s_r, s_nxt;

    // Saturate a wide value into a signed range
    function automatic logic signed [15:0] clamp(input logic signed [31:0] v,
            input logic signed [15:0] lo, input logic signed [15:0] hi);
        if (v > 32'(hi)) begin
            return hi;
        end else if (v < 32'(lo)) begin
            return lo;
        end
        return v[15:0];
    endfunction : clamp

    // Register read mux, fed with the already updated copy
    function automatic logic [31:0] rd(input coc_state_s s, input logic [7:0] a);
        unique case (a)
            ADDR_CTRL: rd = {21'h0, s.ctrl};
            ADDR_MV_IN: rd = {16'h0, s.mv_in};
            ADDR_LIMIT: rd = {s.lo_lim, s.up_lim};
            ADDR_RATE: rd = {16'h0, s.rate};
            ADDR_STOP_MV: rd = {s.err_mv, s.stop_mv};
            ADDR_SPLIT: rd = {s.cool_gain, s.neutral_zone_width};
            ADDR_HYST: rd = {s.cool_switch_hyst, s.heat_hyst};
            ADDR_VALVE: rd = {s.valve_db, s.travel};
            ADDR_VALVE_CFG: rd = {12'h0, s.err_act, s.stop_act, s.oc_hyst};
            ADDR_DEV: rd = {16'h0, s.dev};
            ADDR_STATUS: rd = {11'h0, s.cal != CAL_IDLE, s.v_close, s.v_open,
                               s.cool_on, s.heat_on, s.out_mv};
            ADDR_OUTS: rd = {s.cool_mv, s.heat_mv};
            default: rd = 32'h0000_0000;
        endcase
    endfunction : rd

    // Working signals of the output path
    logic split, valve, run, manual, pverr, onoff_act, rate_act, clamp_act;
    logic signed [15:0] half, rated, lim, lo_rng, e_valve;
    logic signed [31:0] step_lo, step_hi, cool_w;
    logic [1:0] act;

    // ==========================================================
    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        // Bus data phase write, then address phase capture
        if (s_r.wr_pend) begin
            unique case (s_r.wr_addr)
                ADDR_CTRL: s_nxt.ctrl = hwdata[10:0];
                ADDR_MV_IN: s_nxt.mv_in = hwdata[15:0];
                ADDR_LIMIT: {s_nxt.lo_lim, s_nxt.up_lim} = hwdata;
                ADDR_RATE: s_nxt.rate = hwdata[15:0];
                ADDR_STOP_MV: {s_nxt.err_mv, s_nxt.stop_mv} = hwdata;
                ADDR_SPLIT: {s_nxt.cool_gain, s_nxt.neutral_zone_width} = hwdata;
                ADDR_HYST: {s_nxt.cool_switch_hyst, s_nxt.heat_hyst} = hwdata;
                ADDR_VALVE: {s_nxt.valve_db, s_nxt.travel} = hwdata;
                ADDR_VALVE_CFG: {s_nxt.err_act, s_nxt.stop_act, s_nxt.oc_hyst} = hwdata[19:0];
                ADDR_DEV: s_nxt.dev = hwdata[15:0];
                default: s_nxt.ctrl = s_nxt.ctrl; // Unmapped or read-only: ignored
            endcase
        end
        s_nxt.wr_pend = hsel && hready && htrans[1] && hwrite;
        s_nxt.wr_addr = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            s_nxt.hrdata = (haddr[31:8] == 24'h0) ? rd(s_nxt, haddr[7:0]) : 32'h0000_0000;
        end
        if (s_nxt.wr_pend && haddr[31:8] != 24'h0) begin
            s_nxt.wr_pend = 1'b0;
        end

        // One-second tick from the bus clock
        s_nxt.tick = (s_r.tick_cnt == 25'(TICK_CYCLES - 1));
        s_nxt.tick_cnt = s_nxt.tick ? 25'h0 : s_r.tick_cnt + 25'h1;

        // Operating conditions
        split = (s_r.ctrl[CTRL_METHOD +: 2] == METH_SPLIT);
        valve = s_r.ctrl[CTRL_VALVE];
        run = s_r.ctrl[CTRL_RUN];
        manual = s_r.ctrl[CTRL_MANUAL];
        pverr = s_r.ctrl[CTRL_PVERR];
        onoff_act = s_r.ctrl[CTRL_ONOFF] && !valve;
        rate_act = !(onoff_act || manual || !run || pverr || s_r.ctrl[CTRL_AT_RUN]);
        clamp_act = !(onoff_act || manual || !run || pverr || valve);
        half = s_r.neutral_zone_width >>> 1;
        lo_rng = split ? -MV_FULL : 16'sh0000;

        // Rate limiter moves at most one step per tick, then clamp
        step_lo = 32'(s_r.out_mv) - 32'(s_r.rate);
        step_hi = 32'(s_r.out_mv) + 32'(s_r.rate);
        if (rate_act && s_r.rate != 16'h0) begin
            // Step bounds saturate first so a wrap cannot invert the window
            rated = s_r.tick ? clamp(32'(s_r.mv_in), clamp(step_lo, -MV_FULL, MV_FULL),
                    clamp(step_hi, -MV_FULL, MV_FULL)) : s_r.out_mv;
        end else begin
            rated = s_r.mv_in;
        end
        lim = clamp(32'(rated), lo_rng, MV_FULL);
        if (clamp_act) begin
            lim = clamp(32'(lim), s_r.lo_lim, s_r.up_lim);
        end
        if (!run) begin
            lim = s_r.stop_mv;
        end else if (pverr) begin
            lim = s_r.err_mv;
        end
        s_nxt.out_mv = lim;

        // Route the signed value to heat and cool outputs
        s_nxt.dir = (s_r.ctrl[CTRL_METHOD +: 2] == METH_COOL);
        cool_w = 32'h0;
        if (valve) begin
            s_nxt.heat_mv = 16'h0;
            s_nxt.cool_mv = 16'h0;
        end else if (!run || pverr) begin
            s_nxt.heat_mv = lim > 0 ? lim : 16'h0;
            s_nxt.cool_mv = (split && lim < 0) ? -lim : 16'h0;
        end else if (split) begin
            s_nxt.heat_mv = clamp(32'(lim) - 32'(half), 16'sh0000, MV_FULL);
            // Signed arithmetic throughout: heating values must give a negative cool term
            cool_w = (-32'(lim) - 32'(half)) * $signed(32'(GAIN_ONE));
            cool_w = cool_w / $signed(32'((s_r.cool_gain == 16'h0) ? 16'h1 : s_r.cool_gain));
            s_nxt.cool_mv = clamp(cool_w, 16'sh0000, MV_FULL);
        end else begin
            s_nxt.heat_mv = lim > 0 ? lim : 16'h0;
            s_nxt.cool_mv = 16'h0;
        end

        // ON/OFF switching with hysteresis on the deviation
        s_nxt.heat_on = 1'b0;
        s_nxt.cool_on = 1'b0;
        if (onoff_act && run && !pverr) begin
            if (split) begin
                s_nxt.heat_on = s_r.heat_on ? (s_r.dev > half) :
                        (32'(s_r.dev) >= 32'(half) + $signed(32'(s_r.heat_hyst)));
                s_nxt.cool_on = s_r.cool_on ? (-s_r.dev > half) :
                        (-32'(s_r.dev) >= 32'(half) + $signed(32'(s_r.cool_switch_hyst)));
            end else if (s_nxt.dir) begin
                s_nxt.heat_on = s_r.heat_on ? (s_r.dev < 0) :
                        (-32'(s_r.dev) >= $signed(32'(s_r.heat_hyst)));
            end else begin
                s_nxt.heat_on = s_r.heat_on ? (s_r.dev > 0) :
                        (32'(s_r.dev) >= $signed(32'(s_r.heat_hyst)));
            end
            s_nxt.heat_mv = s_nxt.heat_on ? MV_FULL : 16'h0;
            s_nxt.cool_mv = s_nxt.cool_on ? MV_FULL : 16'h0;
        end

        // Valve drive: dead band with open/close hysteresis
        e_valve = lim - $signed(valve_pos);
        act = !run ? s_r.stop_act : s_r.err_act;
        s_nxt.v_open = 1'b0;
        s_nxt.v_close = 1'b0;
        if (valve && (!run || pverr)) begin
            s_nxt.v_open = (act == ACT_OPEN);
            s_nxt.v_close = (act == ACT_CLOSE);
        end else if (valve) begin
            s_nxt.v_open = s_r.v_open ? (32'(e_valve) > $signed(32'(s_r.valve_db))
                    - $signed(32'(s_r.oc_hyst))) :
                    (e_valve > $signed(s_r.valve_db));
            s_nxt.v_close = s_r.v_close ? (-32'(e_valve) > $signed(32'(s_r.valve_db))
                    - $signed(32'(s_r.oc_hyst))) :
                    (-e_valve > $signed(s_r.valve_db));
        end

        // Calibration: close fully, then count seconds to full open
        unique case (s_r.cal)
            CAL_IDLE: begin
                if (s_r.ctrl[CTRL_CAL] && valve) begin
                    s_nxt.cal = CAL_SHUT;
                end
            end
            CAL_SHUT: begin
                s_nxt.v_open = 1'b0;
                s_nxt.v_close = 1'b1;
                s_nxt.cal_secs = 16'h0;
                if (valve_pos == 16'h0) begin
                    s_nxt.cal = CAL_SWEEP;
                end
            end
            CAL_SWEEP: begin
                s_nxt.v_open = 1'b1;
                s_nxt.v_close = 1'b0;
                if (s_r.tick) begin
                    s_nxt.cal_secs = s_r.cal_secs + 16'h1;
                end
                if ($signed(valve_pos) >= MV_FULL) begin
                    s_nxt.travel = (s_r.cal_secs == 16'h0) ? 16'h1 : s_r.cal_secs;
                    s_nxt.cal = CAL_IDLE;
                end
            end
        endcase
        if (s_r.ctrl[CTRL_CAL] && !s_r.wr_pend) begin
            s_nxt.ctrl[CTRL_CAL] = 1'b0; // Self-clearing start bit
        end

        // Features that valve variants switch off
        s_nxt.feat = valve ? 4'h0 : {1'b1, 1'b1, s_r.ctrl[CTRL_AT40] && !split,
                s_r.ctrl[CTRL_PD]};
    end

    // ==========================================================
    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.ctrl[CTRL_METHOD +: 2] <= METH_HEAT;
            s_r.ctrl[CTRL_RUN] <= 1'b1;
            s_r.up_lim <= UP_LIM_RST;
            s_r.lo_lim <= LO_LIM_RST;
            s_r.stop_mv <= STOP_MV_RST;
            s_r.err_mv <= STOP_MV_RST;
            s_r.neutral_zone_width <= NZ_RST;
            s_r.cool_gain <= GAIN_ONE;
            s_r.travel <= TRAVEL_RST;
            s_r.valve_db <= VALVE_DB_RST;
            s_r.stop_act <= ACT_HOLD;
            s_r.err_act <= ACT_HOLD;
            s_r.cal <= CAL_IDLE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state flops; hreadyout and hresp are constants
    assign hrdata = s_r.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign heat_mv = s_r.heat_mv;
    assign cool_mv = s_r.cool_mv;
    assign heat_on = s_r.heat_on;
    assign cool_on = s_r.cool_on;
    assign valve_open = s_r.v_open;
    assign valve_close = s_r.v_close;
    assign action_direction = s_r.dir;
    assign {heater_open_alarm_en, loop_break_alarm_en, at40_en, pd_en} = s_r.feat;

    // ==========================================================
    // Checks
    a_valve_excl: assert property (@(posedge hclk) disable iff (!hresetn)
        !(valve_open && valve_close)) else $error("valve opened and closed together");
    a_valve_feat: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && s_r.ctrl[CTRL_VALVE] |=> !loop_break_alarm_en && !heater_open_alarm_en)
        else $error("alarm enabled in valve mode");
    a_stop_route: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !s_r.ctrl[CTRL_RUN] && !s_r.ctrl[CTRL_VALVE] && s_r.stop_mv < 0 |=> heat_mv == 0)
        else $error("negative stop value reached heat output");
    a_stop_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !s_r.ctrl[CTRL_RUN] && s_r.stop_mv == 0 && !s_r.ctrl[CTRL_ONOFF] |=>
        heat_mv == 0 && cool_mv == 0) else $error("outputs driven with zero stop value");
    a_clamp_hi: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && clamp_act |=> s_r.out_mv <= $past(s_r.up_lim))
        else $error("output above upper limit");
    a_rate_step: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && rate_act && s_r.rate != 0 |=>
        (s_r.out_mv - $past(s_r.out_mv) <= $signed($past(s_r.rate))))
        else $error("rate step too large");
    a_rate_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && rate_act && s_r.rate != 0 && !s_r.tick |=> $stable(s_r.out_mv))
        else $error("output moved between ticks");
    a_onoff_three: assert property (@(posedge hclk) disable iff (!hresetn)
        !(heat_on && cool_on)) else $error("heat and cool both on");
    a_onoff_pid: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && s_r.ctrl[CTRL_VALVE] |=> !heat_on && !cool_on)
        else $error("on/off active in valve mode");
endmodule : coc_top
`default_nettype wire

/* hw/coc_pkg.sv */
/*
 * Constants, register map and state codes of the control output conditioner.
 * Assumes a 25 MHz bus clock and manipulated values in units of 0.1 percent.
 */
package coc_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MV_IN = 8'h04;
    localparam logic [7:0] ADDR_LIMIT = 8'h08;
    localparam logic [7:0] ADDR_RATE = 8'h0C;
    localparam logic [7:0] ADDR_STOP_MV = 8'h10;
    localparam logic [7:0] ADDR_SPLIT = 8'h14;
    localparam logic [7:0] ADDR_HYST = 8'h18;
    localparam logic [7:0] ADDR_VALVE = 8'h1C;
    localparam logic [7:0] ADDR_VALVE_CFG = 8'h20;
    localparam logic [7:0] ADDR_DEV = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_OUTS = 8'h2C;
    // ==========================================================
    // Control register field positions
    localparam int CTRL_METHOD = 0;
    localparam int CTRL_ONOFF = 2;
    localparam int CTRL_VALVE = 3;
    localparam int CTRL_RUN = 4;
    localparam int CTRL_MANUAL = 5;
    localparam int CTRL_PVERR = 6;
    localparam int CTRL_AT_RUN = 7;
    localparam int CTRL_AT40 = 8;
    localparam int CTRL_PD = 9;
    localparam int CTRL_CAL = 10;
    // ==========================================================
    // Methods and valve actions
    localparam logic [1:0] METH_HEAT = 2'h0;
    localparam logic [1:0] METH_COOL = 2'h1;
    localparam logic [1:0] METH_SPLIT = 2'h2;
    localparam logic [1:0] ACT_OPEN = 2'h0;
    localparam logic [1:0] ACT_CLOSE = 2'h1;
    localparam logic [1:0] ACT_HOLD = 2'h2;
    // ==========================================================
    // Reset values and scales
    localparam logic signed [15:0] MV_FULL = 16'sh03E8;
    localparam logic signed [15:0] UP_LIM_RST = 16'sh03E8;
    localparam logic signed [15:0] LO_LIM_RST = -16'sh03E8;
    localparam logic signed [15:0] NZ_RST = 16'sh0000;
    localparam logic signed [15:0] STOP_MV_RST = 16'sh0000;
    localparam logic [15:0] GAIN_ONE = 16'h0064;
    localparam logic [15:0] TRAVEL_RST = 16'h001E;
    localparam logic [15:0] VALVE_DB_RST = 16'h0014;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int TICK_SEC = 1;
    localparam int TICK_CYC = CLK_HZ * TICK_SEC;
    // Calibration sequencer, one-hot
    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_SHUT = 3'b010,
        CAL_SWEEP = 3'b100
    } coc_cal_e;
endpackage : coc_pkg

/* verif/coc_valve_model.sv */
/*
 * Motorised valve seen from the conditioner: travels while driven and
 * reports its opening on the position feedback.
 * Assumes open and close are level outputs that are registered on hclk.
 */
`timescale 1ns/1ns
`default_nettype none
module coc_valve_model #(
    parameter int STEP = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Drive from the conditioner
    input wire logic valve_open,
    input wire logic valve_close,
    // Position feedback, 0..1000
    output logic [15:0] valve_pos
);
    // ==========================================================
    // Travel; both drives at once is a fault, so the valve stays put
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valve_pos <= 16'h01F4;
        end else if (valve_open && !valve_close) begin
            valve_pos <= (valve_pos > 16'h03E8 - 16'(STEP)) ? 16'h03E8 : valve_pos + 16'(STEP);
        end else if (valve_close && !valve_open) begin
            valve_pos <= (valve_pos < 16'(STEP)) ? 16'h0000 : valve_pos - 16'(STEP);
        end
    end
endmodule : coc_valve_model
`default_nettype wire

/* verif/tb.sv */
/*
 * Testbench: register tasks over AHB-Lite and checks of the outputs.
 * Assumes a zero-wait slave and a ten-cycle second tick.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import coc_pkg::*;
    // ==========================================================
    // Signals
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [15:0] valve_pos, heat_mv, cool_mv;
    logic heat_on, cool_on, valve_open, valve_close, action_direction;
    logic lba_en, hoa_en, at40_en, pd_en;
    int n_mismatch, checks_done, cyc, i;
    assign hready = hreadyout;
    coc_top #(.TICK_CYCLES(10)) uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .valve_pos(valve_pos), .heat_mv(heat_mv), .cool_mv(cool_mv),
        .heat_on(heat_on), .cool_on(cool_on), .valve_open(valve_open),
        .valve_close(valve_close), .action_direction(action_direction),
        .loop_break_alarm_en(lba_en), .heater_open_alarm_en(hoa_en),
        .at40_en(at40_en), .pd_en(pd_en));
    coc_valve_model #(.STEP(2)) valve (.hclk(hclk), .hresetn(hresetn),
        .valve_open(valve_open), .valve_close(valve_close), .valve_pos(valve_pos));
    // ==========================================================
    // Clock and hang guard; the ceiling is far above the few thousand cycles used
    always #20 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end
    // ==========================================================
    // Tasks
    task give_verdict();
        if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done = checks_done + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge hclk);
    endtask : wt
    // Address phase held until hready, then data phase held until hready
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] v);
        xfer(a, 1'b1, v);
    endtask : wr
    task rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0000_0000);
        chk("register", e, d);
    endtask : rchk
    // Outputs land one cycle after the write; three leaves margin
    task oc(input logic [15:0] eh, input logic [15:0] ec);
        wt(3);
        chk("heat_mv", 32'(eh), 32'(heat_mv));
        chk("cool_mv", 32'(ec), 32'(cool_mv));
    endtask : oc
    task onoff(input logic [15:0] dev, input logic eh, input logic ec);
        wr(ADDR_DEV, 32'(dev));
        wt(3);
        chk("heat_on", 32'(eh), 32'(heat_on));
        chk("cool_on", 32'(ec), 32'(cool_on));
    endtask : onoff
    // ==========================================================
    // Main sequence
    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
        hwdata = 0; n_mismatch = 0; checks_done = 0; cyc = 0;
        wt(20);
        hresetn <= 1'b1;
        rchk(ADDR_CTRL, 32'h0000_0010);
        rchk(ADDR_SPLIT, 32'h0064_0000);
        rchk(ADDR_STOP_MV, 32'h0000_0000);
        rchk(ADDR_VALVE, 32'h0014_001E);
        wr(ADDR_VALVE, 32'h0014_0028);
        rchk(ADDR_VALVE, 32'h0014_0028);
        wr(8'h30, 32'h0000_1234);
        rchk(8'h30, 32'h0000_0000);
        // Method routing and direction
        wr(ADDR_MV_IN, 32'h0000_01F4);
        oc(16'h01F4, 16'h0000);
        chk("direction", 32'h0000_0000, 32'(action_direction));
        wr(ADDR_CTRL, 32'h0000_0011);
        oc(16'h01F4, 16'h0000);
        chk("direction", 32'h0000_0001, 32'(action_direction));
        wr(ADDR_CTRL, 32'h0000_0012);
        wr(ADDR_MV_IN, 32'h0000_FE70);
        oc(16'h0000, 16'h0190);
        wr(ADDR_SPLIT, 32'h00C8_0000);
        oc(16'h0000, 16'h00C8);
        wr(ADDR_SPLIT, 32'h0064_0064);
        oc(16'h0000, 16'h015E);
        wr(ADDR_SPLIT, 32'h00C8_0064);
        oc(16'h0000, 16'h00AF);
        // Clamp: upper on heat side, lower on cool side
        wr(ADDR_SPLIT, 32'h0064_0000);
        wr(ADDR_LIMIT, 32'hFED4_0258);
        wr(ADDR_MV_IN, 32'h0000_0384);
        oc(16'h0258, 16'h0000);
        wr(ADDR_MV_IN, 32'h0000_FCE0);
        oc(16'h0000, 16'h012C);
        // Stop value routing, limiter idle while stopped
        wr(ADDR_CTRL, 32'h0000_0002);
        wr(ADDR_STOP_MV, 32'h0000_FF06);
        oc(16'h0000, 16'h00FA);
        wr(ADDR_STOP_MV, 32'h0000_0384);
        oc(16'h0384, 16'h0000);
        wr(ADDR_STOP_MV, 32'h0000_0000);
        oc(16'h0000, 16'h0000);
        // Rate limit steps per tick, then manual bypass
        wr(ADDR_LIMIT, 32'hFC18_03E8);
        wr(ADDR_CTRL, 32'h0000_0010);
        wr(ADDR_MV_IN, 32'h0000_0000);
        wr(ADDR_RATE, 32'h0000_0064);
        wt(3);
        wr(ADDR_MV_IN, 32'h0000_015E);
        wt(2);
        chk("rate_step", 32'h0000_0001, 32'(heat_mv <= 16'h0064));
        wt(80);
        chk("heat_mv", 32'h0000_015E, 32'(heat_mv));
        wr(ADDR_CTRL, 32'h0000_0030);
        wr(ADDR_MV_IN, 32'h0000_0000);
        oc(16'h0000, 16'h0000);
        wr(ADDR_RATE, 32'h0000_0000);
        // ON/OFF with hysteresis, then three-state split
        wr(ADDR_HYST, 32'h0014_0014);
        wr(ADDR_CTRL, 32'h0000_0014);
        onoff(16'h0064, 1'b1, 1'b0);
        onoff(16'h000A, 1'b1, 1'b0);
        onoff(16'h0000, 1'b0, 1'b0);
        onoff(16'h000A, 1'b0, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0015);
        onoff(16'hFF9C, 1'b1, 1'b0);
        wr(ADDR_SPLIT, 32'h0064_0064);
        wr(ADDR_CTRL, 32'h0000_0016);
        onoff(16'hFF9C, 1'b0, 1'b1);
        onoff(16'h0000, 1'b0, 1'b0);
        onoff(16'h0064, 1'b1, 1'b0);
        // Valve variant: features off, open/close drive
        wr(ADDR_CTRL, 32'h0000_0310);
        wt(3);
        chk("pd_en", 32'h0000_0001, 32'(pd_en));
        chk("at40_en", 32'h0000_0001, 32'(at40_en));
        wr(ADDR_CTRL, 32'h0000_031C);
        wt(3);
        chk("features", 32'h0000_0000, 32'({lba_en, hoa_en, at40_en, pd_en, heat_on}));
        wr(ADDR_CTRL, 32'h0000_0018);
        wr(ADDR_MV_IN, 32'h0000_0320);
        wt(3);
        chk("open", 32'h0000_0002, 32'({valve_open, valve_close}));
        wt(300);
        chk("pos_in_band", 32'h0000_0001, 32'(valve_pos >= 16'h030C && valve_pos <= 16'h0334));
        chk("drive", 32'h0000_0000, 32'({valve_open, valve_close}));
        wr(ADDR_CTRL, 32'h0000_0008);
        wt(3);
        chk("hold", 32'h0000_0000, 32'({valve_open, valve_close}));
        wr(ADDR_VALVE_CFG, 32'h0008_0000);
        wt(3);
        chk("stop_open", 32'h0000_0002, 32'({valve_open, valve_close}));
        // Calibration measures full travel: 500 cycles at ten per second
        wr(ADDR_CTRL, 32'h0000_0418);
        for (i = 0; i < 1500; i++) begin
            xfer(ADDR_STATUS, 1'b0, 32'h0000_0000);
            if (d[20] === 1'b0 && i > 2) break;
        end
        xfer(ADDR_VALVE, 1'b0, 32'h0000_0000);
        chk("travel", 32'h0000_0001, 32'(d[15:0] >= 16'h0031 && d[15:0] <= 16'h0033));
        give_verdict();
    end
endmodule : tb
`default_nettype wire
